// *** design/qenc_top.sv ***
// Quadrature encoder interface: position integrator, velocity capture and event status.
// Assumes encoder pins and control levels are synchronous-safe inputs on a single 20 MHz core_clk.
//
// Summary of operation
// - Zero on signal_interp_sel picks quadrature decoding, one picks step plus direction.
// - Quadrature mode derives direction from which phase edge comes first.
// - Step/direction mode counts each A edge, direction from B level.
// - Quadrature edge select counts A edges only or both A and B edges.
// - A edges leading B edges increment the position.
// - B edges leading A edges decrement the position.
// - In quadrature mode, two successive edges on one phase flag a direction change.
// - Swap option exchanges the two phases before decoding.
// - Velocity capture runs only while position tracking is enabled.
// - Wrap source zero clears position on each index pulse.
// - Stepping backward from zero loads the position ceiling.
// - Wrap source one bounds position to zero..ceiling and ignores index.
// - Velocity tally uses the same decoded edges as the position counter.
// - Velocity timer counts down, flags expiry at zero and reloads.
// - A power-of-two prescaler divides edges fed to the velocity tally.
// - Edge select gives two counted edges per line cleared, four set.
// - Phase error, direction change, index and timer events are sticky, maskable, clearable.
// - With halt freeze enabled, debug halt stops counters and timer.
// - Index polarity flip inverts the index input.
`timescale 1ns/100ps
module qenc_top
#(
   parameter int POS_W = 32,
   parameter int TMR_W = 32
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic quad_in_a,
   input wire logic quad_in_b,
   input wire logic index_in,
   input wire logic encoder_en,
   input wire logic velocity_en,
   input wire logic signal_interp_sel,
   input wire logic edge_count_sel,
   input wire logic swap_en,
   input wire logic wrap_source_sel,
   input wire logic [qenc_pkg::QENC_DIV_W-1:0] velocity_prescale,
   input wire logic halt_freeze_en,
   input wire logic debug_halt,
   input wire logic index_polarity_flip,
   input wire logic [POS_W-1:0] position_ceiling,
   input wire logic [TMR_W-1:0] period_reload,
   input wire logic [qenc_pkg::QENC_EV_W-1:0] event_mask,
   input wire logic [qenc_pkg::QENC_EV_W-1:0] event_clear,
   output logic [POS_W-1:0] position,
   output logic direction,
   output logic [TMR_W-1:0] timer_value,
   output logic [POS_W-1:0] running_edge_tally,
   output logic [POS_W-1:0] period_edge_total,
   output logic [qenc_pkg::QENC_EV_W-1:0] raw_status,
   output logic [qenc_pkg::QENC_EV_W-1:0] masked_status,
   output logic event_irq
);
   import qenc_pkg::*;

   // Counters wider than the 32-bit host view could not be read whole, so the widths are bounded.
   if (POS_W < 2 || POS_W > 32 || TMR_W < 2 || TMR_W > 32)
   begin : g_width_check
      $error("qenc_top: POS_W and TMR_W must lie in 2..32.");
   end

   typedef struct packed {
      logic [POS_W-1:0] pos;
      logic [POS_W-1:0] tally;
      logic [POS_W-1:0] total;
      logic [TMR_W-1:0] timer;
      logic [QENC_PRE_W-1:0] pre;
      logic [QENC_EV_W-1:0] raw;
   } qenc_top_t;

   qenc_top_t q;
   qenc_top_t d;
   logic run;
   logic vrun;
   logic expire;
   logic tally_inc;
   logic [QENC_EV_W-1:0] events;

   qenc_if u_evt();

   qenc_decode u_decode
   (
      .core_clk(core_clk),
      .reset(reset),
      .quad_in_a(quad_in_a),
      .quad_in_b(quad_in_b),
      .index_in(index_in),
      .signal_interp_sel(signal_interp_sel),
      .edge_count_sel(edge_count_sel),
      .swap_en(swap_en),
      .index_polarity_flip(index_polarity_flip),
      .evt(u_evt)
   );

   // Prescaler terminal count for a divide by two to the power p.
   function automatic logic [QENC_PRE_W-1:0] pre_limit(input logic [QENC_DIV_W-1:0] p);
      logic [QENC_PRE_W:0] one_hot;
      one_hot = (QENC_PRE_W+1)'(1) << p;
      return QENC_PRE_W'(one_hot - (QENC_PRE_W+1)'(1));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      d = q;
      run = encoder_en & ~(halt_freeze_en & debug_halt);
      vrun = run & velocity_en;
      expire = vrun && (q.timer == '0);
      tally_inc = 1'b0;
      if (run && u_evt.step)
      begin
         if (u_evt.fwd)
         begin
            d.pos = (q.pos == position_ceiling) ? '0 : q.pos + POS_W'(1);
         end
         else
         begin
            d.pos = (q.pos == '0) ? position_ceiling : q.pos - POS_W'(1);
         end
      end
      if (run && u_evt.index_hit && wrap_source_sel == QENC_WRAP_INDEX)
      begin
         d.pos = '0;
      end
      if (vrun && u_evt.step)
      begin
         if (q.pre >= pre_limit(velocity_prescale))
         begin
            d.pre = '0;
            tally_inc = 1'b1;
         end
         else
         begin
            d.pre = q.pre + QENC_PRE_W'(1);
         end
      end
      if (vrun)
      begin
         d.tally = q.tally + POS_W'(tally_inc);
      end
      // An edge arriving on the expiry cycle opens the new period rather than being lost.
      if (expire)
      begin
         d.total = q.tally;
         d.tally = POS_W'(tally_inc);
         d.timer = period_reload;
      end
      else if (vrun)
      begin
         d.timer = q.timer - TMR_W'(1);
      end
      events = '0;
      events[QENC_EV_INDEX] = run & u_evt.index_hit;
      events[QENC_EV_TIMER] = expire;
      events[QENC_EV_DIR] = run & u_evt.dir_chg;
      events[QENC_EV_ERR] = run & u_evt.phase_err;
      d.raw = (q.raw & ~event_clear) | events;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         q <= '0;
         q.raw <= QENC_EV_RST;
      end
      else
      begin
         q <= d;
      end
   end

   assign position = q.pos;
   assign direction = u_evt.fwd;
   assign timer_value = q.timer;
   assign running_edge_tally = q.tally;
   assign period_edge_total = q.total;
   assign raw_status = q.raw;
   assign masked_status = q.raw & event_mask;
   assign event_irq = |(q.raw & event_mask);

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_step_plain;
      run && u_evt.step && !(u_evt.index_hit && wrap_source_sel == QENC_WRAP_INDEX);
   endsequence
   sequence s_expire;
      vrun && q.timer == '0;
   endsequence

   a_pos_up_one: assert property (s_step_plain and (u_evt.fwd && q.pos != position_ceiling)
      |=> q.pos == $past(q.pos) + POS_W'(1)) else $error("Forward step did not increment.");
   a_pos_down_one: assert property (s_step_plain and (!u_evt.fwd && q.pos != '0)
      |=> q.pos == $past(q.pos) - POS_W'(1)) else $error("Backward step did not decrement.");
   a_pos_under_wrap: assert property (s_step_plain and (!u_evt.fwd && q.pos == '0)
      |=> q.pos == $past(position_ceiling)) else $error("Underflow did not load ceiling.");
   a_ceiling_wrap: assert property (s_step_plain and (u_evt.fwd && q.pos == position_ceiling)
      |=> q.pos == '0) else $error("Ceiling did not wrap to zero.");
   a_index_clear: assert property (run && u_evt.index_hit && wrap_source_sel == QENC_WRAP_INDEX
      |=> q.pos == '0) else $error("Index did not clear position.");
   a_index_ignored: assert property (run && !u_evt.step && wrap_source_sel == QENC_WRAP_CEIL
      |=> $stable(q.pos)) else $error("Position moved without a step.");
   a_timer_reload: assert property (s_expire |=> q.timer == $past(period_reload)
      && q.raw[QENC_EV_TIMER]) else $error("Timer expiry did not reload.");
   a_speed_capture: assert property (s_expire |=> q.total == $past(q.tally)
      && q.tally <= POS_W'(1)) else $error("Period total not captured.");
   a_vel_gated: assert property (!encoder_en |=> $stable(q.tally) && $stable(q.timer))
      else $error("Velocity ran without position tracking.");
   a_halt_freeze: assert property (halt_freeze_en && debug_halt |=> $stable(q.pos)
      && $stable(q.timer) && $stable(q.tally)) else $error("Counters moved while halted.");
   a_set_wins: assert property (run && u_evt.phase_err && event_clear[QENC_EV_ERR]
      |=> q.raw[QENC_EV_ERR]) else $error("Phase error lost to clear.");
   a_sticky_hold: assert property (q.raw[QENC_EV_DIR] && !event_clear[QENC_EV_DIR]
      |=> q.raw[QENC_EV_DIR] && (event_irq || !event_mask[QENC_EV_DIR])) else $error("Event bit dropped.");
endmodule

// *** include/qenc_pkg.sv ***
// Constants shared by the quadrature encoder decoder and its top level.
// Assumes one 20 MHz clock domain and a synchronous, active-high reset.
package qenc_pkg;
   localparam int QENC_EV_W = 4;
   localparam int QENC_EV_INDEX = 0;
   localparam int QENC_EV_TIMER = 1;
   localparam int QENC_EV_DIR = 2;
   localparam int QENC_EV_ERR = 3;
   localparam int QENC_DIV_W = 3;
   localparam int QENC_PRE_W = 7;
   localparam logic [1:0] QENC_FILL_DONE = 2'h3;
   localparam logic QENC_SIG_QUAD = 1'b0;
   localparam logic QENC_WRAP_INDEX = 1'b0;
   localparam logic QENC_WRAP_CEIL = 1'b1;
   localparam logic [QENC_EV_W-1:0] QENC_EV_RST = 4'h0;
endpackage

// *** include/qenc_if.sv ***
// Decoded encoder events passed from the decoder to the counting core.
// Assumes both ends share core_clk; every signal here comes from a flip-flop.
`timescale 1ns/100ps
interface qenc_if;
   logic step;
   logic fwd;
   logic dir_chg;
   logic phase_err;
   logic index_hit;
   modport dec (output step, output fwd, output dir_chg, output phase_err, output index_hit);
   modport core (input step, input fwd, input dir_chg, input phase_err, input index_hit);
endinterface

// *** design/qenc_decode.sv ***
// Input synchroniser and phase decoder of the quadrature encoder block.
// Assumes encoder pins are slow against core_clk; all outputs are one-cycle pulses or levels from flops.
`timescale 1ns/100ps
module qenc_decode
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic quad_in_a,
   input wire logic quad_in_b,
   input wire logic index_in,
   input wire logic signal_interp_sel,
   input wire logic edge_count_sel,
   input wire logic swap_en,
   input wire logic index_polarity_flip,
   qenc_if.dec evt
);
   import qenc_pkg::*;

   typedef struct packed {
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic [1:0] sync_i;
      logic [1:0] fill;
      logic prev_a;
      logic prev_b;
      logic prev_i;
      logic last_b;
      logic seen;
      logic fwd;
      logic step;
      logic dir_chg;
      logic phase_err;
      logic index_hit;
   } qenc_dec_t;

   qenc_dec_t q;
   qenc_dec_t d;
   logic ph_a;
   logic ph_b;
   logic idx;
   logic edge_a;
   logic edge_b;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      d = q;
      d.step = 1'b0;
      d.dir_chg = 1'b0;
      d.phase_err = 1'b0;
      d.index_hit = 1'b0;
      d.sync_a = {q.sync_a[0], quad_in_a};
      d.sync_b = {q.sync_b[0], quad_in_b};
      d.sync_i = {q.sync_i[0], index_in};
      ph_a = swap_en ? q.sync_b[1] : q.sync_a[1];
      ph_b = swap_en ? q.sync_a[1] : q.sync_b[1];
      idx = q.sync_i[1] ^ index_polarity_flip;
      edge_a = ph_a ^ q.prev_a;
      edge_b = ph_b ^ q.prev_b;
      d.prev_a = ph_a;
      d.prev_b = ph_b;
      d.prev_i = idx;
      // Until the chain has filled, stale flop values would look like edges.
      if (q.fill != QENC_FILL_DONE)
      begin
         d.fill = q.fill + 2'h1;
      end
      else
      begin
         d.index_hit = idx & ~q.prev_i;
         if (signal_interp_sel == QENC_SIG_QUAD)
         begin
            d.phase_err = edge_a & edge_b;
            if (edge_a ^ edge_b)
            begin
               d.step = edge_a | edge_count_sel;
               d.fwd = ph_a ^ q.prev_b;
               // A first edge after reset has no earlier edge to compare with, so it never reports a reversal.
               d.dir_chg = q.seen && (edge_b == q.last_b);
               d.last_b = edge_b;
               d.seen = 1'b1;
            end
         end
         else if (edge_a)
         begin
            d.step = 1'b1;
            d.fwd = ph_b;
            d.dir_chg = q.seen && (ph_b != q.fwd);
            d.seen = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign evt.step = q.step;
   assign evt.fwd = q.fwd;
   assign evt.dir_chg = q.dir_chg;
   assign evt.phase_err = q.phase_err;
   assign evt.index_hit = q.index_hit;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_quad_both_err: assert property (q.fill == QENC_FILL_DONE && signal_interp_sel == QENC_SIG_QUAD
      && edge_a && edge_b |=> q.phase_err && !q.step) else $error("Double phase change not flagged.");
   a_quad_fwd_step: assert property (q.fill == QENC_FILL_DONE && signal_interp_sel == QENC_SIG_QUAD
      && edge_a && !edge_b && ph_a != ph_b |=> q.step && q.fwd) else $error("A-leads-B edge not forward.");
   a_clkdir_step: assert property (q.fill == QENC_FILL_DONE && signal_interp_sel != QENC_SIG_QUAD
      && edge_a |=> q.step && q.fwd == $past(ph_b)) else $error("Step/direction edge not decoded.");
endmodule

// *** tb/qenc_enc_model.sv ***
// Behavioural rotary encoder that drives quadrature or step/direction phases and an index pulse.
// Assumes one caller at a time. Each level is held HOLD clocks so that the four-clock decode path settles.
`timescale 1ns/100ps
module qenc_enc_model
#(
   parameter int HOLD = 6
)
(
   input wire logic core_clk,
   output logic quad_in_a,
   output logic quad_in_b,
   output logic index_in
);
   initial
   begin
      quad_in_a = 1'b0;
      quad_in_b = 1'b0;
      index_in = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wait_edge(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   // Moves one quarter cycle in quadrature, or makes one step edge after the direction level is set.
   task automatic move(input logic fwd, input logic quad);
      wait_edge(1);
      if (quad)
      begin
         if ((quad_in_a == quad_in_b) == fwd)
            quad_in_a = ~quad_in_a;
         else
            quad_in_b = ~quad_in_b;
      end
      else
      begin
         // Direction settles two clocks before the step, so the two never share a sample.
         quad_in_b = fwd;
         wait_edge(2);
         quad_in_a = ~quad_in_a;
      end
      wait_edge(HOLD);
   endtask
   // Changes both phases in one sample, which no real encoder should do.
   task automatic both_phases();
      wait_edge(1);
      quad_in_a = ~quad_in_a;
      quad_in_b = ~quad_in_b;
      wait_edge(HOLD);
   endtask
   task automatic index_level(input logic lvl);
      wait_edge(1);
      index_in = lvl;
      wait_edge(HOLD);
   endtask
   task automatic index_pulse();
      index_level(1'b1);
      index_level(1'b0);
   endtask
endmodule

// *** tb/qenc_top_tb.sv ***
// Self-checking bench for the quadrature encoder block: a table of decode cases, then hand-written cases.
// Assumes the encoder model holds every level long enough for a decoded edge to reach the outputs.
`timescale 1ns/100ps
module qenc_top_tb;
   import qenc_pkg::*;
   typedef struct {
      logic sig;
      logic edg;
      logic swp;
      logic fwd;
      logic [7:0] n;
      logic [31:0] ceil;
      logic [31:0] pos;
      logic dir;
   } qenc_row_t;
   logic core_clk, reset, quad_in_a, quad_in_b, index_in, encoder_en, velocity_en, signal_interp_sel;
   logic edge_count_sel, swap_en, wrap_source_sel, halt_freeze_en, debug_halt, index_polarity_flip;
   logic event_irq, direction;
   logic [2:0] velocity_prescale;
   logic [3:0] event_mask, event_clear, raw_status, masked_status;
   logic [31:0] position_ceiling, period_reload, position, timer_value, running_edge_tally, period_edge_total;
   int failures = 0;
   int comparisons = 0;
   int k;
   qenc_row_t rows [7] = '{
      '{1'b0, 1'b1, 1'b0, 1'b1, 8'h8, 32'h63, 32'h8, 1'b1},
      '{1'b0, 1'b0, 1'b0, 1'b1, 8'h8, 32'h63, 32'h4, 1'b1},
      '{1'b0, 1'b1, 1'b1, 1'b1, 8'h8, 32'h63, 32'h5C, 1'b0},
      '{1'b0, 1'b1, 1'b0, 1'b0, 8'h4, 32'h63, 32'h60, 1'b0},
      '{1'b0, 1'b1, 1'b0, 1'b1, 8'h5, 32'h3, 32'h1, 1'b1},
      '{1'b1, 1'b0, 1'b0, 1'b1, 8'h6, 32'h63, 32'h6, 1'b1},
      '{1'b1, 1'b0, 1'b0, 1'b0, 8'h6, 32'h63, 32'h5E, 1'b0}
   };
   qenc_top i_qenc_top (.core_clk(core_clk), .reset(reset), .quad_in_a(quad_in_a), .quad_in_b(quad_in_b),
      .index_in(index_in), .encoder_en(encoder_en), .velocity_en(velocity_en),
      .signal_interp_sel(signal_interp_sel), .edge_count_sel(edge_count_sel), .swap_en(swap_en),
      .wrap_source_sel(wrap_source_sel), .velocity_prescale(velocity_prescale), .halt_freeze_en(halt_freeze_en),
      .debug_halt(debug_halt), .index_polarity_flip(index_polarity_flip), .position_ceiling(position_ceiling),
      .period_reload(period_reload), .event_mask(event_mask), .event_clear(event_clear), .position(position),
      .direction(direction), .timer_value(timer_value), .running_edge_tally(running_edge_tally),
      .period_edge_total(period_edge_total), .raw_status(raw_status), .masked_status(masked_status),
      .event_irq(event_irq));
   qenc_enc_model i_qenc_enc_model (.core_clk(core_clk), .quad_in_a(quad_in_a), .quad_in_b(quad_in_b),
      .index_in(index_in));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (failures == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // The decoder needs three clocks after release to fill its synchroniser, so four are allowed.
   task automatic do_reset();
      tick(1);
      reset = 1'b1;
      tick(2);
      reset = 1'b0;
      tick(4);
   endtask
   task automatic pulse_clear();
      event_clear = 4'hF;
      tick(1);
      event_clear = 4'h0;
      tick(1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {reset, encoder_en, velocity_en, signal_interp_sel, edge_count_sel, swap_en} = 6'h30;
      {halt_freeze_en, debug_halt, index_polarity_flip, wrap_source_sel} = {3'h0, QENC_WRAP_CEIL};
      {velocity_prescale, event_mask, event_clear, position_ceiling, period_reload} = 75'h0;
      tick(2);
      reset = 1'b0;
      foreach (rows[i])
      begin
         do_reset();
         {signal_interp_sel, edge_count_sel, swap_en} = {rows[i].sig, rows[i].edg, rows[i].swp};
         position_ceiling = rows[i].ceil;
         repeat (rows[i].n) i_qenc_enc_model.move(rows[i].fwd, !rows[i].sig);
         check("position", position, rows[i].pos);
         check("direction", 32'(direction), 32'(rows[i].dir));
         check("no reversal", 32'(raw_status[QENC_EV_DIR]), 32'h0);
         check("timer off", timer_value, 32'h0);
      end
      // A reversal, then its masking and clearing, then an illegal double change.
      {signal_interp_sel, edge_count_sel, swap_en, position_ceiling} = {3'h2, 32'h63};
      do_reset();
      check("reset raw", 32'(raw_status), 32'h0);
      event_mask = 4'hF;
      i_qenc_enc_model.move(1'b1, 1'b1);
      i_qenc_enc_model.move(1'b0, 1'b1);
      check("reversal", 32'(raw_status[QENC_EV_DIR]), 32'h1);
      check("irq", 32'(event_irq), 32'h1);
      check("masked dir", 32'(masked_status), 32'h4);
      event_mask = 4'h0;
      tick(1);
      check("masked", 32'({masked_status, event_irq}), 32'h0);
      pulse_clear();
      check("cleared", 32'(raw_status), 32'h0);
      i_qenc_enc_model.both_phases();
      check("phase error", 32'(raw_status[QENC_EV_ERR]), 32'h1);
      check("no step", position, 32'h0);
      {halt_freeze_en, debug_halt} = 2'h3;
      i_qenc_enc_model.move(1'b1, 1'b1);
      check("frozen", position, 32'h0);
      {halt_freeze_en, debug_halt} = 2'h0;
      repeat (2) i_qenc_enc_model.move(1'b1, 1'b1);
      i_qenc_enc_model.index_pulse();
      check("index ignored", position, 32'h2);
      wrap_source_sel = QENC_WRAP_INDEX;
      i_qenc_enc_model.index_pulse();
      check("index zero", position, 32'h0);
      check("index event", 32'(raw_status[QENC_EV_INDEX]), 32'h1);
      // With the flip set the index counts when the pin falls, not when it rises.
      index_polarity_flip = 1'b1;
      repeat (2) i_qenc_enc_model.move(1'b1, 1'b1);
      i_qenc_enc_model.index_level(1'b1);
      check("flip high", position, 32'h2);
      i_qenc_enc_model.index_level(1'b0);
      check("flip low", position, 32'h0);
      index_polarity_flip = 1'b0;
      // Velocity: the timer must stand while position tracking is off, then run and reload.
      do_reset();
      {encoder_en, velocity_en, velocity_prescale, period_reload} = {2'h1, 3'h2, 32'h3E8};
      tick(5);
      check("timer idle", timer_value, 32'h0);
      encoder_en = 1'b1;
      tick(3);
      pulse_clear();
      repeat (8) i_qenc_enc_model.move(1'b1, 1'b1);
      check("tally", running_edge_tally, 32'h2);
      check("same edges", position, 32'h8);
      for (k = 0; k < 1100 && raw_status[QENC_EV_TIMER] !== 1'b1; k++)
         tick(1);
      if (k == 1100)
      begin
         failures++;
      end
      check("total", period_edge_total, 32'h2);
      check("tally reset", running_edge_tally, 32'h0);
      check("reload", timer_value, 32'h3E8);
      tick(1);
      check("count down", timer_value, 32'h3E7);
      finish_test();
   end
endmodule
